// ### card_model.sv
// ----------------------------------------
// removable card behind the level shifters
// ----------------------------------------
module card_model (
    input wire logic pclk,
    input wire slot_pkg::card_out_t card_out,
    input wire logic [1:0] det,
    input wire logic rdy,
    input wire logic wp,
    input wire logic [1:0] bat,
    input wire logic [3:0] wait_len,
    output slot_pkg::card_in_t card_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] last;
    logic [3:0] wcnt;
    logic strb_d;
    logic strb;
    logic rd;
    assign rd = !card_out.card_oe_n || !card_out.io_read_strobe_n;
    assign strb = rd || !card_out.mem_write_strobe_n || !card_out.io_write_strobe_n;
    initial begin
        last = 16'h0000;
        wcnt = 4'h0;
        strb_d = 1'b0;
    end
    always @(posedge pclk) begin
        strb_d <= strb;
        if (strb && !strb_d) begin
            wcnt <= wait_len;
        end else if (wcnt != 4'h0) begin
            wcnt <= wcnt - 4'h1;
        end
        if (!card_out.mem_write_strobe_n || !card_out.io_write_strobe_n) begin
            mem[card_out.addr[3:0]] <= card_out.data_out;
        end
        if (rd) begin
            last <= mem[card_out.addr[3:0]];
        end
    end
    always_comb begin
        card_in.detect_in_first = det[1];
        card_in.detect_in_second = det[0];
        card_in.card_ready_in = rdy;
        card_in.write_protect_in = wp;
        card_in.battery_in_first = bat[1];
        card_in.battery_in_second = bat[0];
        card_in.card_wait_in = (wcnt == 4'h0);
        // released bus shows the inverse of the last value
        card_in.data_in = rd ? mem[card_out.addr[3:0]] : ~last;
    end
endmodule : card_model

// ### pc_card_slot_controller.sv
`include "slot_defs.svh"

// How it works
// - memory card: change to (0,1) sets warn flag
// - memory card: change to (1,0)/(0,0) sets dead flag
// - I/O card: dead flag reads zero
// - auto-init enable resets general control on detect
// - I/O irq mode: off, low, rising, falling
// - I/O card: status pin falling raises interrupt
// - any detect pin change raises interrupt
// - memory card: ready pin change raises interrupt
// - memory card: warn state raises interrupt
// - memory card: dead state raises interrupt
// - direction high on reads, low on writes
// - space select high common, low attribute
// - gate high isolates, low passes data
// - card wait low extends the access
// - card present only when both detects low
// - battery pins decoded good, replace, lost
// - wait code selects 0..10 states, 000 ignores wait
// - assert delay code selects 1..4 cycles
// - negate delay code selects 1..4 cycles
// - four strobes: oe, we, iord, iowr
// - card type bit selects memory or I/O
module pc_card_slot_controller (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire slot_pkg::card_in_t card_in,
    output slot_pkg::card_out_t card_out,
    output logic slot_irq
);

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [4:0] wait_states(input logic [2:0] code);
        case (code)
            3'h0: wait_states = 5'h00;
            3'h1: wait_states = 5'h01;
            3'h2: wait_states = 5'h02;
            3'h3: wait_states = 5'h03;
            3'h4: wait_states = 5'h04;
            3'h5: wait_states = 5'h06;
            3'h6: wait_states = 5'h08;
            default: wait_states = 5'h0a;
        endcase
    endfunction : wait_states

    function automatic logic is_mapped(input logic [`PADDR_W-1:0] a);
        case (a)
            `OFS_PIN_STATUS, `OFS_GEN_CTRL, `OFS_CHANGE, `OFS_IRQ_EN,
            `OFS_WAIT_CTRL, `OFS_STROBE_TIME, `OFS_ACC_ADDR, `OFS_ACC_DATA,
            `OFS_ACC_GO: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // ----------------------------------------
    // state and helpers
    // ----------------------------------------
    slot_pkg::state_t s;
    slot_pkg::state_t n;
    logic [6:0] cur;
    logic [6:0] prv;
    logic io_mode;
    logic present_now;
    logic present_prev;
    logic bat_chg;
    logic busy;
    logic strobe;
    logic [1:0] bat_pair;
    logic [1:0] bat_code;
    logic [7:0] change_vis;
    logic [1:0] irq_mode;

    assign cur = s.sync2;
    assign prv = s.prev;
    assign io_mode = s.gcr[`GCR_TYPE];
    assign present_now = ~cur[`SY_CD1] & ~cur[`SY_CD2];
    assign present_prev = ~prv[`SY_CD1] & ~prv[`SY_CD2];
    assign bat_pair = {cur[`SY_BV1], cur[`SY_BV2]};
    assign bat_chg = bat_pair != {prv[`SY_BV1], prv[`SY_BV2]};
    assign busy = s.st != slot_pkg::ST_IDLE;
    assign strobe = s.st == slot_pkg::ST_STROBE;
    assign irq_mode = s.ier[`IER_MODE_HI:`IER_MODE_LO];
    // good, replace soon, data lost
    assign bat_code = (bat_pair == 2'h3) ? 2'h0 : (bat_pair == 2'h2) ? 2'h1 : 2'h2;
    assign change_vis = s.csc & (io_mode ? `CSC_IO_MASK : `CSC_MEM_MASK);

    // ----------------------------------------
    // interrupt output
    // ----------------------------------------
    assign slot_irq = change_vis[`CSC_SOFT]
        | (change_vis[`CSC_IREQ] & (irq_mode != 2'h0))
        | (|(change_vis[4:0] & s.ier[4:0]));

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~is_mapped(paddr);
    assign prdata = s.prdata;

    // ----------------------------------------
    // card pins
    // ----------------------------------------
    assign card_out.card_oe_n = ~(strobe & s.dir_rd & ~s.io);
    assign card_out.mem_write_strobe_n = ~(strobe & ~s.dir_rd & ~s.io);
    assign card_out.io_read_strobe_n = ~(strobe & s.dir_rd & s.io);
    assign card_out.io_write_strobe_n = ~(strobe & ~s.dir_rd & s.io);

    assign card_out.card_enable_low_out_n = ~busy;
    assign card_out.card_enable_high_out_n = ~busy;

    assign card_out.transceiver_direction = ~(busy & ~s.dir_rd);
    assign card_out.space_select_out = s.gcr[`GCR_SPACE];
    assign card_out.transceiver_gate = s.gcr[`GCR_GATE];
    assign card_out.card_reset_out = s.gcr[`GCR_CARD_RESET];
    assign card_out.addr = s.addr;
    assign card_out.data_out = s.wdata;
    assign card_out.data_oe = busy & ~s.dir_rd;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic wr;
        logic [7:0] set;
        logic [7:0] clr;
        wr = psel & penable & pwrite;
        set = 8'h00;
        clr = 8'h00;
        n = s;
        n.sync1 = {card_in.card_wait_in, card_in.battery_in_second, card_in.battery_in_first,
                   card_in.write_protect_in, card_in.card_ready_in,
                   card_in.detect_in_second, card_in.detect_in_first};
        n.sync2 = s.sync1;
        n.prev = s.sync2;

        // change events
        set[`CSC_CDC] = (cur[`SY_CD1] ^ prv[`SY_CD1]) | (cur[`SY_CD2] ^ prv[`SY_CD2]);
        if (io_mode) begin
            case (irq_mode)
                2'h1: set[`CSC_IREQ] = ~cur[`SY_RDY];
                2'h2: set[`CSC_IREQ] = cur[`SY_RDY] & ~prv[`SY_RDY];
                2'h3: set[`CSC_IREQ] = ~cur[`SY_RDY] & prv[`SY_RDY];
                default: set[`CSC_IREQ] = 1'b0;
            endcase
            set[`CSC_SC] = prv[`SY_BV1] & ~cur[`SY_BV1];
        end else begin
            set[`CSC_RC] = cur[`SY_RDY] ^ prv[`SY_RDY];
            if (bat_chg) begin
                set[`CSC_BW] = bat_pair == 2'h1;
                clr[`CSC_BW] = bat_pair != 2'h1;
                set[`CSC_BD] = ~bat_pair[0];
                clr[`CSC_BD] = bat_pair[0];
            end
        end
        if (wr && paddr == `OFS_CHANGE) begin
            clr = clr | (pwdata[7:0] & `CSC_CLR_MASK);
        end
        n.csc = set | (s.csc & ~clr);
        if (wr && paddr == `OFS_CHANGE) begin
            n.csc[`CSC_SOFT] = pwdata[`CSC_SOFT];
        end

        // register writes
        if (wr) begin
            case (paddr)
                `OFS_GEN_CTRL: n.gcr = pwdata[7:0];
                `OFS_IRQ_EN: n.ier = pwdata[7:0];
                `OFS_WAIT_CTRL: n.wcr = pwdata[15:0];
                `OFS_STROBE_TIME: n.card_strobe_timing = pwdata[7:0];
                `OFS_ACC_ADDR: n.addr = pwdata[15:0];
                `OFS_ACC_DATA: n.wdata = pwdata[15:0];
                default: n.gcr = n.gcr;
            endcase
        end
        if (s.ier[`IER_AUTO] && present_now && !present_prev) begin
            n.gcr = `GCR_RESET_VAL;
        end

        // read data taken in the setup cycle
        if (psel && !penable) begin
            case (paddr)
                `OFS_PIN_STATUS: n.prdata = {22'h0, bat_code, cur[`SY_RDY], cur[`SY_WP],
                    present_now, 1'b0, cur[`SY_CD2], cur[`SY_CD1],
                    cur[`SY_BV2], cur[`SY_BV1]};
                `OFS_GEN_CTRL: n.prdata = {24'h0, s.gcr};
                `OFS_CHANGE: n.prdata = {24'h0, change_vis};
                `OFS_IRQ_EN: n.prdata = {24'h0, s.ier};
                `OFS_WAIT_CTRL: n.prdata = {16'h0, s.wcr};
                `OFS_STROBE_TIME: n.prdata = {24'h0, s.card_strobe_timing};
                `OFS_ACC_ADDR: n.prdata = {16'h0, s.addr};
                `OFS_ACC_DATA: n.prdata = {16'h0, s.rdata};
                `OFS_ACC_GO: n.prdata = {31'h0, busy};
                default: n.prdata = 32'h0;
            endcase
        end

        // card access sequencer
        case (s.st)
            slot_pkg::ST_IDLE: begin
                if (wr && paddr == `OFS_ACC_GO) begin
                    n.dir_rd = pwdata[`GO_READ];
                    n.io = pwdata[`GO_IO];
                    n.cnt = {3'h0, s.card_strobe_timing[`ASSERT_HI:`ASSERT_LO]};
                    n.st = slot_pkg::ST_SETUP;
                end
            end
            slot_pkg::ST_SETUP: begin
                if (s.cnt == 5'h00) begin
                    n.cnt = wait_states(s.wcr[`WAIT_HI:`WAIT_LO]);
                    n.st = slot_pkg::ST_STROBE;
                end else begin
                    n.cnt = s.cnt - 5'h01;
                end
            end
            slot_pkg::ST_STROBE: begin
                if (s.cnt != 5'h00) begin
                    n.cnt = s.cnt - 5'h01;
                end else if (s.wcr[`WAIT_HI:`WAIT_LO] != 3'h0 && !cur[`SY_WAIT]) begin
                    n.cnt = s.cnt;
                end else begin
                    if (s.dir_rd) begin
                        n.rdata = card_in.data_in;
                    end
                    n.cnt = {3'h0, s.card_strobe_timing[`NEGATE_HI:`NEGATE_LO]};
                    n.st = slot_pkg::ST_HOLD;
                end
            end
            slot_pkg::ST_HOLD: begin
                if (s.cnt == 5'h00) begin
                    n.st = slot_pkg::ST_IDLE;
                end else begin
                    n.cnt = s.cnt - 5'h01;
                end
            end
            default: n.st = slot_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.sync1 <= `SYNC_IDLE_VAL;
            s.sync2 <= `SYNC_IDLE_VAL;
            s.prev <= `SYNC_IDLE_VAL;
            s.gcr <= `GCR_RESET_VAL;
            s.csc <= `CSC_RESET_VAL;
            s.ier <= `IER_RESET_VAL;
            s.wcr <= `WCR_RESET_VAL;
            s.card_strobe_timing <= `PCR_RESET_VAL;
            s.st <= slot_pkg::ST_IDLE;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_detect_change_flag: assert property (
        (cur[`SY_CD1] != prv[`SY_CD1]) |=> s.csc[`CSC_CDC])
        else $error("detect change did not set its flag");

    a_detect_irq_out: assert property (
        s.csc[`CSC_CDC] && s.ier[3] |-> slot_irq)
        else $error("enabled detect flag without interrupt");

    a_warn_flag_set: assert property (
        !io_mode && bat_chg && bat_pair == 2'h1 && !(psel && penable && pwrite)
        |=> s.csc[`CSC_BW])
        else $error("battery warn flag not set");

    a_dead_flag_clear: assert property (
        !io_mode && bat_chg && bat_pair == 2'h3 |=> !s.csc[`CSC_BD])
        else $error("battery dead flag not cleared");

    a_dead_flag_set: assert property (
        !io_mode && bat_chg && !bat_pair[0] |=> s.csc[`CSC_BD])
        else $error("battery dead flag not set");

    a_ready_change_flag: assert property (
        !io_mode && cur[`SY_RDY] != prv[`SY_RDY] |=> s.csc[`CSC_RC])
        else $error("ready change missed");

    a_irq_level_mode: assert property (
        io_mode && irq_mode == 2'h1 && !cur[`SY_RDY] |=> s.csc[`CSC_IREQ])
        else $error("low level request missed");

    a_io_dead_reads: assert property (
        io_mode && psel && !penable && paddr == `OFS_CHANGE |=> prdata[`CSC_BD] == 1'b0)
        else $error("dead flag visible with I/O card");

    a_auto_init_gcr: assert property (
        s.ier[`IER_AUTO] && present_now && !present_prev |=> s.gcr == `GCR_RESET_VAL)
        else $error("general control not reinitialised");

    a_status_fall_flag: assert property (
        io_mode && prv[`SY_BV1] && !cur[`SY_BV1] |=> s.csc[`CSC_SC])
        else $error("status pin fall missed");

    a_dir_on_write: assert property (
        busy && !s.dir_rd |-> !card_out.transceiver_direction)
        else $error("direction high during write");

    a_strobe_in_phase: assert property (
        !strobe |-> card_out.card_oe_n && card_out.mem_write_strobe_n
            && card_out.io_read_strobe_n && card_out.io_write_strobe_n)
        else $error("strobe outside strobe phase");

    a_setup_short: assert property (
        s.st == slot_pkg::ST_IDLE ##1 s.st == slot_pkg::ST_SETUP && s.cnt == 5'h00
        |=> s.st == slot_pkg::ST_STROBE)
        else $error("setup phase too long");

    a_wait_extends: assert property (
        strobe && s.cnt == 5'h00 && s.wcr[`WAIT_HI:`WAIT_LO] != 3'h0 && !cur[`SY_WAIT]
        |=> strobe ##0 $stable(s.cnt))
        else $error("access ended while wait low");

    a_wait_ignored: assert property (
        strobe && s.cnt == 5'h00 && s.wcr[`WAIT_HI:`WAIT_LO] == 3'h0
        |=> s.st == slot_pkg::ST_HOLD)
        else $error("wait honoured with code zero");

    a_strobe_load: assert property (
        $past(s.st) == slot_pkg::ST_SETUP && strobe
        |-> s.cnt == wait_states($past(s.wcr[`WAIT_HI:`WAIT_LO])))
        else $error("wrong wait state count");

    a_hold_exit: assert property (
        s.st == slot_pkg::ST_HOLD && s.cnt == 5'h00 |=> s.st == slot_pkg::ST_IDLE)
        else $error("hold phase overran");

    a_single_strobe: assert property (
        $onehot0(~{card_out.card_oe_n, card_out.mem_write_strobe_n,
                   card_out.io_read_strobe_n, card_out.io_write_strobe_n}))
        else $error("more than one strobe active");


    // ----------------------------------------
    // covers
    // ----------------------------------------
    c_mem_read: cover property (strobe && s.dir_rd && !s.io ##1 s.st == slot_pkg::ST_HOLD);

    c_io_write: cover property (strobe && !s.dir_rd && s.io);

    c_wait_stretch: cover property (strobe && s.cnt == 5'h00 && !cur[`SY_WAIT] ##1 strobe);

    c_irq_raised: cover property (!slot_irq ##1 slot_irq);


endmodule : pc_card_slot_controller

// ### slot_defs.svh
`ifndef SLOT_DEFS_SVH
`define SLOT_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PADDR_W 8
`define OFS_PIN_STATUS 8'h00
`define OFS_GEN_CTRL 8'h04
`define OFS_CHANGE 8'h08
`define OFS_IRQ_EN 8'h0c
`define OFS_WAIT_CTRL 8'h10
`define OFS_STROBE_TIME 8'h14
`define OFS_ACC_ADDR 8'h18
`define OFS_ACC_DATA 8'h1c
`define OFS_ACC_GO 8'h20

// ----------------------------------------
// reset values
// ----------------------------------------
`define GCR_RESET_VAL 8'h00
`define IER_RESET_VAL 8'h00
`define CSC_RESET_VAL 8'h00
`define WCR_RESET_VAL 16'h0000
`define PCR_RESET_VAL 8'h00
`define SYNC_IDLE_VAL 7'h7f

// ----------------------------------------
// slot_general_control fields
// ----------------------------------------
`define GCR_GATE 7
`define GCR_CARD_RESET 6
`define GCR_TYPE 5
`define GCR_SPACE 0

// ----------------------------------------
// card_status_change fields and masks
// ----------------------------------------
`define CSC_SOFT 7
`define CSC_IREQ 5
`define CSC_SC 4
`define CSC_CDC 3
`define CSC_RC 2
`define CSC_BW 1
`define CSC_BD 0
`define CSC_IO_MASK 8'hb8
`define CSC_MEM_MASK 8'h8f
`define CSC_CLR_MASK 8'h3f

// ----------------------------------------
// status_change_irq_enable fields
// ----------------------------------------
`define IER_AUTO 7
`define IER_MODE_HI 6
`define IER_MODE_LO 5

// ----------------------------------------
// timing fields
// ----------------------------------------
`define WAIT_HI 15
`define WAIT_LO 13
`define ASSERT_HI 5
`define ASSERT_LO 4
`define NEGATE_HI 1
`define NEGATE_LO 0

// ----------------------------------------
// access start fields
// ----------------------------------------
`define GO_READ 0
`define GO_IO 1

// ----------------------------------------
// synchroniser bit positions
// ----------------------------------------
`define SY_CD1 0
`define SY_CD2 1
`define SY_RDY 2
`define SY_WP 3
`define SY_BV1 4
`define SY_BV2 5
`define SY_WAIT 6

`endif

// ### slot_pkg.sv
package slot_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} access_st_t;

    typedef struct packed {
        logic detect_in_first;
        logic detect_in_second;
        logic card_ready_in;
        logic write_protect_in;
        logic battery_in_first;
        logic battery_in_second;
        logic card_wait_in;
        logic [15:0] data_in;
    } card_in_t;

    typedef struct packed {
        logic card_oe_n;
        logic mem_write_strobe_n;
        logic io_read_strobe_n;
        logic io_write_strobe_n;
        logic card_enable_low_out_n;
        logic card_enable_high_out_n;
        logic transceiver_direction;
        logic space_select_out;
        logic transceiver_gate;
        logic card_reset_out;
        logic [15:0] addr;
        logic [15:0] data_out;
        logic data_oe;
    } card_out_t;

    typedef struct packed {
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [6:0] prev;
        logic [7:0] gcr;
        logic [7:0] csc;
        logic [7:0] ier;
        logic [15:0] wcr;
        logic [7:0] card_strobe_timing;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic dir_rd;
        logic io;
        access_st_t st;
        logic [4:0] cnt;
        logic [31:0] prdata;
    } state_t;

endpackage : slot_pkg

// ### tb_pc_card_slot_controller.sv
`include "slot_defs.svh"

module tb_pc_card_slot_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slot_irq, rdy, wp;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic err_v, dir_or, dir_and;
    slot_pkg::card_in_t card_in;
    slot_pkg::card_out_t card_out;
    logic [1:0] det, bat;
    logic [3:0] wait_len, smask;
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 2630;
    int en_cnt, st_cnt;
    int wst[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
    int exp_mem[int];

    pc_card_slot_controller pc_card_slot_controller_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_in(card_in),
        .card_out(card_out), .slot_irq(slot_irq));
    card_model card_model_i (.pclk(pclk), .card_out(card_out), .det(det), .rdy(rdy),
        .wp(wp), .bat(bat), .wait_len(wait_len), .card_in(card_in));

    // ----------------------------------------
    // access monitor
    // ----------------------------------------
    always @(posedge pclk) begin
        if (card_out.card_enable_low_out_n === 1'b0) begin
            en_cnt++;
            smask = smask | ~{card_out.card_oe_n, card_out.mem_write_strobe_n,
                card_out.io_read_strobe_n, card_out.io_write_strobe_n};
            if (smask != 4'h0 && (card_out.card_oe_n & card_out.mem_write_strobe_n
                & card_out.io_read_strobe_n & card_out.io_write_strobe_n) === 1'b0) begin
                st_cnt++;
            end
            dir_or = dir_or | card_out.transceiver_direction;
            dir_and = dir_and & card_out.transceiver_direction;
        end
    end

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            report_and_stop();
        end
    endtask : apb

    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string what);
        apb(1'b0, a, 32'h0);
        check(what, e, rd_v & m);
    endtask : rdm

    task automatic access(input logic io, input logic rd, input int a, input int h, input int c);
        int n;
        int ws;
        ws = wst[c];
        apb(1'b1, `OFS_STROBE_TIME, 32'(a * 16 + h));
        apb(1'b1, `OFS_WAIT_CTRL, 32'(c * 8192));
        en_cnt = 0;
        st_cnt = 0;
        smask = 4'h0;
        dir_or = 1'b0;
        dir_and = 1'b1;
        apb(1'b1, `OFS_ACC_GO, {30'h0, io, rd});
        n = 0;
        do begin
            tick(1);
            n++;
        end while (card_out.card_enable_low_out_n !== 1'b1 && n < 300);
        if (n >= 300) begin
            num_errors++;
            report_and_stop();
        end
        check("strobe kind", io ? (rd ? 2 : 1) : (rd ? 8 : 4), smask);
        if (wait_len == 4'h0) begin
            check("strobe cycles", ws + 1, st_cnt);
            check("access cycles", a + h + ws + 3, en_cnt);
        end else begin
            check("wait stretch", c != 0, st_cnt > ws + 1);
        end
        check("direction", rd, rd ? dir_and : dir_or);
        rdm(`OFS_ACC_GO, 32'h1, 32'h0, "busy");
    endtask : access

    initial begin
        int i;
        int m;
        logic [31:0] v;
        logic [1:0] p;
        logic [7:0] ra[4] = '{`OFS_GEN_CTRL, `OFS_IRQ_EN, `OFS_WAIT_CTRL, `OFS_STROBE_TIME};
        logic [31:0] rm[4] = '{32'he1, 32'hff, 32'he000, 32'h33};
        logic [1:0] bq[$] = '{2'b01, 2'b10, 2'b00, 2'b11};
        {psel, penable, pwrite, presetn, paddr, pwdata} = '0;
        {det, rdy, wp, bat, wait_len} = {2'b11, 1'b1, 1'b1, 2'b11, 4'h0};
        tick(4);
        presetn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            rdm(i < 4 ? ra[i] : `OFS_CHANGE, 32'hffffffff, 32'h0, "reset value");
        end
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped error", 1, err_v);
        check("unmapped data", 0, rd_v);
        for (i = 0; i < 8; i++) begin
            v = $random(seed) & rm[i % 4];
            apb(1'b1, ra[i % 4], v);
            rdm(ra[i % 4], rm[i % 4], v, "register readback");
        end
        for (i = 0; i < 4; i++) begin
            apb(1'b1, ra[i], 32'h0);
        end
        $display("test registers done");
        apb(1'b1, `OFS_IRQ_EN, 32'h08);
        det <= 2'b01;
        tick(5);
        rdm(`OFS_PIN_STATUS, 32'h20, 32'h0, "present one pin");
        rdm(`OFS_CHANGE, 32'h08, 32'h08, "detect flag");
        check("detect irq", 1, slot_irq);
        det <= 2'b00;
        tick(5);
        rdm(`OFS_PIN_STATUS, 32'h20, 32'h20, "present both");
        apb(1'b1, `OFS_CHANGE, 32'h08);
        tick(3);
        rdm(`OFS_CHANGE, 32'hff, 32'h0, "detect cleared");
        check("irq cleared", 0, slot_irq);
        apb(1'b1, `OFS_IRQ_EN, 32'h80);
        det <= 2'b11;
        tick(5);
        check("detect irq off", 0, slot_irq);
        apb(1'b1, `OFS_GEN_CTRL, 32'h81);
        tick(1);
        check("space select", 1, card_out.space_select_out);
        check("gate", 1, card_out.transceiver_gate);
        det <= 2'b00;
        tick(5);
        rdm(`OFS_GEN_CTRL, 32'hff, 32'h0, "auto init");
        apb(1'b1, `OFS_IRQ_EN, 32'h0);
        det <= 2'b11;
        tick(5);
        apb(1'b1, `OFS_GEN_CTRL, 32'h81);
        det <= 2'b00;
        tick(5);
        rdm(`OFS_GEN_CTRL, 32'hff, 32'h81, "no auto init");
        apb(1'b1, `OFS_CHANGE, 32'h3f);
        $display("test detect done");
        apb(1'b1, `OFS_GEN_CTRL, 32'h01);
        apb(1'b1, `OFS_IRQ_EN, 32'h04);
        rdy <= 1'b0;
        tick(5);
        rdm(`OFS_CHANGE, 32'h04, 32'h04, "ready flag");
        check("ready irq", 1, slot_irq);
        apb(1'b1, `OFS_CHANGE, 32'h3f);
        apb(1'b1, `OFS_GEN_CTRL, 32'h20);
        rdy <= 1'b1;
        tick(5);
        rdm(`OFS_CHANGE, 32'h04, 32'h0, "ready flag io");
        for (m = 0; m < 4; m++) begin
            apb(1'b1, `OFS_IRQ_EN, 32'(m * 32));
            rdy <= 1'b0;
            tick(5);
            rdm(`OFS_CHANGE, 32'h20, 32'(m % 2) << 5, "irq mode low");
            rdy <= 1'b1;
            tick(5);
            rdm(`OFS_CHANGE, 32'h20, 32'(m != 0) << 5, "irq mode high");
            check("card irq", m != 0, slot_irq);
            apb(1'b1, `OFS_CHANGE, 32'h3f);
        end
        for (m = 1; m >= 0; m--) begin
            apb(1'b1, `OFS_IRQ_EN, 32'(m * 16));
            bat <= 2'b00;
            tick(5);
            rdm(`OFS_CHANGE, 32'h13, 32'h10, "status pin flag");
            check("status irq", m, slot_irq);
            bat <= 2'b11;
            tick(5);
            apb(1'b1, `OFS_CHANGE, 32'h3f);
        end
        apb(1'b1, `OFS_GEN_CTRL, 32'h0);
        apb(1'b1, `OFS_IRQ_EN, 32'h03);
        foreach (bq[i]) begin
            p = bq[i];
            bat <= p;
            tick(5);
            rdm(`OFS_CHANGE, 32'h03, {p == 2'b01, !p[0]}, "battery flags");
            rdm(`OFS_PIN_STATUS, 32'h300, p[1] ? (p[0] ? 0 : 32'h100) : 32'h200,
                "battery code");
            check("battery irq", p != 2'b11, slot_irq);
        end
        apb(1'b1, `OFS_IRQ_EN, 32'h0);
        $display("test status flags done");
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            exp_mem[i] = v[15:0];
            apb(1'b1, `OFS_ACC_ADDR, 32'(i));
            apb(1'b1, `OFS_ACC_DATA, v);
            access(i % 2, 1'b0, v[17:16], v[21:20], i);
            access(i % 2, 1'b1, v[25:24], v[29:28], i);
            rdm(`OFS_ACC_DATA, 32'hffff, 32'(exp_mem[i]), "card read data");
        end
        wait_len <= 4'h6;
        access(1'b0, 1'b1, 0, 0, 3);
        access(1'b1, 1'b0, 0, 0, 0);
        $display("test accesses done");
        report_and_stop();
    end
endmodule : tb_pc_card_slot_controller
